// ---- hdl/clkcfg_pkg.sv ----
// package: register map, field layout and decoded types for the clock/regulator config block
`default_nettype none
package clkcfg_pkg;
  // printed offsets are not all multiples of four: they are register indexes, byte address = 4*index
  localparam logic [15:0] IDX_REGULATOR_CONTROL = 16'h2866;
  localparam logic [15:0] IDX_CLOCK_CONTROL = 16'h2867;
  localparam logic [15:0] IDX_PLL_CONTROL = 16'h2868;
  localparam logic [15:0] IDX_RC_OSCILLATOR_TRIM = 16'h2869;
  localparam int ADDR_W = 18;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  // regulator_control fields
  localparam int REG3V3_POWER_DOWN_BIT = 7;
  localparam int REG3V3_BIAS_BOOST_BIT = 6;
  localparam int REG3V3_TRIM_HI = 4;
  localparam int REG3V3_TRIM_LO = 3;
  localparam int REG1V8_TRIM_HI = 1;
  localparam int REG1V8_TRIM_LO = 0;
  // clock_control fields
  localparam int PLL_ENABLE_BIT = 7;
  localparam int VREF_ENABLE_BIT = 6;
  localparam int SAMPLING_MUL_HI = 5;
  localparam int SAMPLING_MUL_LO = 4;
  localparam int METERING_MUL_HI = 3;
  localparam int METERING_MUL_LO = 2;
  localparam int CPU_MUL_HI = 1;
  localparam int CPU_MUL_LO = 0;
  // pll_control fields
  localparam int CPU_SECOND_DOUBLER_BIT = 7;
  localparam int CPU_FIRST_DOUBLER_BIT = 6;
  localparam int GRID_SELECT_BIT = 5;
  // rc_oscillator_trim field
  localparam int RC_TRIM_HI = 7;
  localparam int RC_TRIM_LO = 4;
  // writable masks: reserved bits read back as zero
  localparam logic [7:0] MASK_REGULATOR = 8'hdb;
  localparam logic [7:0] MASK_CLOCK = 8'hff;
  localparam logic [7:0] MASK_PLL = 8'he0;
  localparam logic [7:0] MASK_RC_TRIM = 8'hf0;
  // multiplier field codes
  localparam logic [1:0] MUL_X1 = 2'h0;
  localparam logic [1:0] MUL_X2 = 2'h1;
  localparam logic [1:0] MUL_X4 = 2'h2;
  localparam logic [1:0] MUL_X8 = 2'h3;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CLKCFG_TRIM_NONE = 2'b00,
    CLKCFG_TRIM_PLUS_0V1 = 2'b01,
    CLKCFG_TRIM_MINUS_0V2 = 2'b10,
    CLKCFG_TRIM_MINUS_0V1 = 2'b11
  } clkcfg_vtrim_t;

  // analog control bundle leaving the block
  typedef struct packed {
    logic reg3v3_power_down;
    logic reg3v3_bias_boost;
    clkcfg_vtrim_t reg3v3_voltage_trim;
    clkcfg_vtrim_t reg1v8_voltage_trim;
    logic pll_enable;
    logic voltage_reference_enable;
    logic grid_frequency_select;
    logic [3:0] rc_oscillator_trim_code;
  } clkcfg_analog_t;

  // one-hot clock multipliers: bit n set means times 2**n
  typedef struct packed {
    logic [2:0] sampling_clock_mul;
    logic [2:0] metering_clock_mul;
    logic [5:0] cpu_clock_mul;
  } clkcfg_clocks_t;
endpackage
`default_nettype wire

// ---- hdl/clkcfg_regs.sv ----
// clkcfg_regs: AXI4-Lite register file steering regulators, PLL and clock multipliers
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`default_nettype none
// How it works
// - the 3.3 V regulator power-down output follows bit 7 of regulator_control (1 = off).
// - bit 6 of regulator_control drives the bias-boost output that doubles regulator bias.
// - bits 4:3 of regulator_control drive the 3.3 V regulator trim code.
// - bits 1:0 of regulator_control drive the 1.8 V regulator trim code.
// - bit 7 of clock_control enables the PLL, reset value disabled.
// - bit 6 of clock_control enables the voltage reference, reset value disabled.
// - bits 5:4 of clock_control pick sampling clock x1, x2 or x4 of 204.8 kHz.
// - bits 3:2 of clock_control pick metering clock x1, x2 or x4 of 819.2 kHz.
// - bits 1:0 of clock_control pick cpu clock x1, x2, x4 or x8 of 819.2 kHz.
// - pll_control bit 6 doubles the cpu clock beyond the chosen multiplier.
// - pll_control bit 7 doubles the cpu clock again only when bit 6 is also set.
// - pll_control bit 5 selects 50 Hz (0) or 60 Hz (1) grid for the PLL.
// - bits 7:4 of rc_oscillator_trim drive the 32768 Hz RC oscillator trim code.
module clkcfg_regs (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [clkcfg_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [clkcfg_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output clkcfg_pkg::clkcfg_analog_t analog_out,
  output clkcfg_pkg::clkcfg_clocks_t clocks_out
);
  import clkcfg_pkg::*;

  logic [7:0] regulator_control_reg;
  logic [7:0] clock_control_reg;
  logic [7:0] pll_control_reg;
  logic [7:0] rc_oscillator_trim_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic aw_have_reg;
  logic [7:0] w_byte_reg;
  logic w_lane_reg;
  logic w_have_reg;
  logic do_write;
  logic [15:0] w_index;
  logic [15:0] r_index;
  logic [7:0] r_byte;
  logic r_hit;
  logic w_hit;
  logic [2:0] sampling_next;
  logic [2:0] metering_next;
  logic [5:0] cpu_next;
  logic [3:0] cpu_base;

  // write address and data may arrive in either order; each is held until both are in
  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
  assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign w_index = 16'(aw_addr_reg[ADDR_W-1:2]);
  assign w_hit = (aw_addr_reg[1:0] == 2'h0) &&
                 (w_index >= IDX_REGULATOR_CONTROL) && (w_index <= IDX_RC_OSCILLATOR_TRIM);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (do_write) begin
      aw_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      w_have_reg <= 1'b0;
      w_byte_reg <= 8'h00;
      w_lane_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_reg <= 1'b1;
      w_byte_reg <= s_axi_wdata[7:0];
      w_lane_reg <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= w_hit ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // reserved bits are masked so they always hold and read zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regulator_control_reg <= RESET_VALUE;
      clock_control_reg <= RESET_VALUE;
      pll_control_reg <= RESET_VALUE;
      rc_oscillator_trim_reg <= RESET_VALUE;
    end else if (do_write && w_hit && w_lane_reg) begin
      case (w_index)
        IDX_REGULATOR_CONTROL: regulator_control_reg <= w_byte_reg & MASK_REGULATOR;
        IDX_CLOCK_CONTROL: clock_control_reg <= w_byte_reg & MASK_CLOCK;
        IDX_PLL_CONTROL: pll_control_reg <= w_byte_reg & MASK_PLL;
        IDX_RC_OSCILLATOR_TRIM: rc_oscillator_trim_reg <= w_byte_reg & MASK_RC_TRIM;
        default: ;
      endcase
    end
  end

  // read channel: one read at a time, answered the cycle after acceptance
  assign s_axi_arready = !s_axi_rvalid;
  assign r_index = 16'(s_axi_araddr[ADDR_W-1:2]);

  always_comb begin
    r_hit = (s_axi_araddr[1:0] == 2'h0);
    case (r_index)
      IDX_REGULATOR_CONTROL: r_byte = regulator_control_reg;
      IDX_CLOCK_CONTROL: r_byte = clock_control_reg;
      IDX_PLL_CONTROL: r_byte = pll_control_reg;
      IDX_RC_OSCILLATOR_TRIM: r_byte = rc_oscillator_trim_reg;
      default: begin
        r_byte = 8'h00;
        r_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, r_hit ? r_byte : 8'h00};
      s_axi_rresp <= r_hit ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // analog controls; the vref-before-PLL order is left to software, no interlock here
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      analog_out <= '0;
    end else begin
      analog_out.reg3v3_power_down <= regulator_control_reg[REG3V3_POWER_DOWN_BIT];
      analog_out.reg3v3_bias_boost <= regulator_control_reg[REG3V3_BIAS_BOOST_BIT];
      analog_out.reg3v3_voltage_trim <=
        clkcfg_vtrim_t'(regulator_control_reg[REG3V3_TRIM_HI:REG3V3_TRIM_LO]);
      analog_out.reg1v8_voltage_trim <=
        clkcfg_vtrim_t'(regulator_control_reg[REG1V8_TRIM_HI:REG1V8_TRIM_LO]);
      analog_out.pll_enable <= clock_control_reg[PLL_ENABLE_BIT];
      analog_out.voltage_reference_enable <= clock_control_reg[VREF_ENABLE_BIT];
      analog_out.grid_frequency_select <= pll_control_reg[GRID_SELECT_BIT];
      analog_out.rc_oscillator_trim_code <=
        rc_oscillator_trim_reg[RC_TRIM_HI:RC_TRIM_LO];
    end
  end

  // multiplier decode into one-hot exponents
  always_comb begin
    case (clock_control_reg[SAMPLING_MUL_HI:SAMPLING_MUL_LO])
      MUL_X2: sampling_next = 3'h2;
      MUL_X4: sampling_next = 3'h4;
      default: sampling_next = 3'h1;
    endcase
    case (clock_control_reg[METERING_MUL_HI:METERING_MUL_LO])
      MUL_X2: metering_next = 3'h2;
      MUL_X4: metering_next = 3'h4;
      default: metering_next = 3'h1;
    endcase
    case (clock_control_reg[CPU_MUL_HI:CPU_MUL_LO])
      MUL_X1: cpu_base = 4'h1;
      MUL_X2: cpu_base = 4'h2;
      MUL_X4: cpu_base = 4'h4;
      MUL_X8: cpu_base = 4'h8;
      default: cpu_base = 4'h1;
    endcase
    // second doubler is ignored unless the first is set
    case ({pll_control_reg[CPU_SECOND_DOUBLER_BIT], pll_control_reg[CPU_FIRST_DOUBLER_BIT]})
      2'b01: cpu_next = {1'b0, cpu_base, 1'b0};
      2'b11: cpu_next = {cpu_base, 2'b00};
      default: cpu_next = {2'b00, cpu_base};
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clocks_out <= {3'h1, 3'h1, 6'h01};
    end else begin
      clocks_out.sampling_clock_mul <= sampling_next;
      clocks_out.metering_clock_mul <= metering_next;
      clocks_out.cpu_clock_mul <= cpu_next;
    end
  end
endmodule
`default_nettype wire

// ---- verification/clkcfg_regs_asserts.sv ----
// checker: bus handshake and output relations of the clock/regulator config block
`default_nettype none
module clkcfg_regs_asserts
  import clkcfg_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire clkcfg_pkg::clkcfg_analog_t analog_out,
  input wire clkcfg_pkg::clkcfg_clocks_t clocks_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // saturating age of the last accepted write word
  logic [2:0] wr_age;
  always_ff @(posedge clk) begin
    if (sys_rst) wr_age <= 3'h7;
    else if (s_axi_wvalid && s_axi_wready) wr_age <= 3'h0;
    else if (wr_age != 3'h7) wr_age <= wr_age + 3'h1;
  end
  chk_read_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp == AXI_SLVERR |->
      s_axi_rdata == 32'h0)
    else $error("error read returned data");
  chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken during response");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during response");
  chk_samp_hot: assert property ($onehot(clocks_out.sampling_clock_mul))
    else $error("sampling multiplier not one-hot");
  chk_meter_hot: assert property ($onehot(clocks_out.metering_clock_mul))
    else $error("metering multiplier not one-hot");
  chk_cpu_hot: assert property ($onehot(clocks_out.cpu_clock_mul))
    else $error("cpu multiplier not one-hot");
  chk_out_cause: assert property (!$stable(analog_out) || !$stable(clocks_out) |-> wr_age <= 3'h4)
    else $error("outputs changed without a write");
  cov_write: cover property (wr_age == 3'h2);
  cov_slverr: cover property (s_axi_rvalid && s_axi_rresp == AXI_SLVERR);
  cov_cpu_max: cover property (clocks_out.cpu_clock_mul == 6'h20);
endmodule
bind clkcfg_regs clkcfg_regs_asserts i_chk (.*);
`default_nettype wire

// ---- verification/tb_clock_ldo_config_regs.sv ----
// testbench: register traffic and output checks for the clock/regulator config block
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb_clock_ldo_config_regs import clkcfg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, sys_rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  clkcfg_analog_t analog_out;
  clkcfg_clocks_t clocks_out;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [7:0] m[4];
  logic [7:0] msk[4] = '{MASK_REGULATOR, MASK_CLOCK, MASK_PLL, MASK_RC_TRIM};
  int n_errors = 0, checks = 0;
  clkcfg_regs i_dut (.*);
  always #5 clk = ~clk;
  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [17:0] ad(int i);
    return {IDX_REGULATOR_CONTROL + i[15:0], 2'b00};
  endfunction
  function automatic logic [2:0] mul3(logic [1:0] c);
    return (c == 2'h3) ? 3'h1 : 3'h1 << c;
  endfunction
  // bready raised only after bvalid, so a held response is seen
  task automatic wr(logic [17:0] a, logic [7:0] d, logic [3:0] s, logic [1:0] r);
    int k;
    logic ta, tw, tb, tv;
    bq.push_back(r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'($urandom), d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    for (k = 0; k < 50; k++) begin
      @(negedge clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid && s_axi_bready;
      tv = s_axi_bvalid;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (tb) begin
        s_axi_bready <= 0;
        break;
      end
      if (tv) s_axi_bready <= 1;
    end
    if (k == 50) begin
      n_errors++;
      test_done;
    end
  endtask
  task automatic rd(logic [17:0] a, logic [7:0] e, logic [1:0] r);
    int k;
    logic ta, tr;
    rq.push_back({r, 24'h0, e});
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (k = 0; k < 50; k++) begin
      @(negedge clk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid && s_axi_rready;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 0;
      if (tr) begin
        s_axi_rready <= 0;
        break;
      end
    end
    if (k == 50) begin
      n_errors++;
      test_done;
    end
  endtask
  // notes are popped once into locals so a mismatch print cannot pop again
  always @(negedge clk) begin
    logic [33:0] er;
    logic [1:0] eb;
    if (s_axi_rvalid && s_axi_rready) begin
      er = rq.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata}, er)
    end
    if (s_axi_bvalid && s_axi_bready) begin
      eb = bq.pop_front();
      `CHK(s_axi_bresp, eb)
    end
  end
  task automatic check_out;
    logic [2:0] sh;
    logic [14:0] ea;
    repeat (2) @(posedge clk);
    @(negedge clk);
    sh = 3'(m[1][1:0]) + 3'(m[2][6]) + 3'(m[2][6] & m[2][7]);
    ea = {m[0][7:6], m[0][4:3], m[0][1:0], m[1][7:6], m[2][5], m[3][7:4]};
    `CHK(analog_out, clkcfg_analog_t'(ea))
    `CHK(clocks_out, {mul3(m[1][5:4]), mul3(m[1][3:2]), 6'h01 << sh})
  endtask
  task automatic do_reset;
    @(posedge clk);
    sys_rst <= 1;
    repeat (2) @(posedge clk);
    sys_rst <= 0;
    m = '{default: 8'h00};
  endtask
  initial begin
    int i, j;
    logic [7:0] d;
    j = $urandom(83);
    do_reset;
    for (i = 0; i < 4; i++) rd(ad(i), 8'h00, AXI_OKAY);
    check_out;
    // every multiplier and doubler code visited once
    for (i = 0; i < 16; i++) begin
      j = i % 4;
      d = 8'($urandom);
      if (j == 1) d[5:0] = {3{i[3:2]}};
      if (j == 2) d[7:6] = i[3:2];
      // vref stays on, pll only once vref was already on
      if (j == 1) d[7:6] = {d[7] & m[1][6], 1'b1};
      // software keeps reserved bits at zero
      d = d & msk[j];
      wr(ad(j), d, 4'hf, AXI_OKAY);
      m[j] = d & msk[j];
      rd(ad(j), m[j], AXI_OKAY);
      check_out;
    end
    wr(ad(1), 8'h00, 4'he, AXI_OKAY);
    wr(18'h0, 8'hff, 4'hf, AXI_SLVERR);
    rd(18'h0, 8'h00, AXI_SLVERR);
    rd(ad(2) + 18'h1, 8'h00, AXI_SLVERR);
    rd(ad(1), m[1], AXI_OKAY);
    check_out;
    do_reset;
    check_out;
    test_done;
  end
endmodule
`default_nettype wire
